/* rtl/apc_config_regs.sv */
/*
 * Audio processing configuration register bank: two option registers
 * plus a control register, reached over APB, driving decoded controls
 * for the filter chain, limiters, volume and modulator.
 * Assumes a single clock ref_clk, synchronous srst and an APB master.
 */
`timescale 1ns/1ns
`default_nettype none

module apc_config_regs #(
    parameter int NCH = 3,
    parameter int DW  = 24,
    parameter int RUN_LEN = apc_pkg::ZERO_RUN_LEN
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NCH-1:0]    xover_vld,
    input  wire logic [NCH*DW-1:0] xover_data,
    output logic                   highpass_bypass,
    output logic                   deemphasis_enable,
    output logic                   eq_path_bypass,
    output logic                   postscale_link,
    output logic                   coefficient_link,
    output logic                   compression_mode_select,
    output logic                   limiter_track_volume,
    output logic                   sub_mix_enable,
    output logic [NCH-1:0]         channel_mute,
    output logic                   power_corr_coef_select,
    output logic                   power_corr_main_active,
    output logic                   power_corr_line_active,
    output logic                   shaper_order_select,
    output logic                   radio_band_quiet_mode,
    output logic                   modulation_rate_select,
    output logic [19:0]            modulation_rate_hz,
    output logic                   distortion_coef_select,
    output logic                   zero_cross_volume_enable,
    output logic                   soft_volume_enable
);

    // ************************************************************
    // register storage
    // ************************************************************
    logic [7:0] opt_d_q;
    logic [7:0] opt_e_q;
    logic [7:0] ctrl_q;
    logic [NCH-1:0] mute_w;
    logic [NCH-1:0] mute_q;

    // pready is a flop, so every access takes one wait state
    logic wr_en;
    logic rd_en;
    assign wr_en = psel && penable && pwrite && !pready;
    assign rd_en = psel && penable && !pwrite && !pready;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == apc_pkg::OPT_D_ADDR) || (a == apc_pkg::OPT_E_ADDR)
               || (a == apc_pkg::CTRL_ADDR)  || (a == apc_pkg::STAT_ADDR);
    endfunction : addr_ok

    // a byte lane 0 write; lanes above carry no storage
    function automatic logic lane0_wr(input logic [11:0] a,
                                      input logic [11:0] target);
        lane0_wr = (a == target) && pstrb[0];
    endfunction : lane0_wr

    // ************************************************************
    // writes
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            opt_d_q <= apc_pkg::OPT_D_RST;
        end else if (clk_en && wr_en
                     && lane0_wr(paddr, apc_pkg::OPT_D_ADDR)) begin
            opt_d_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            opt_e_q <= apc_pkg::OPT_E_RST;
        end else if (clk_en && wr_en
                     && lane0_wr(paddr, apc_pkg::OPT_E_ADDR)) begin
            opt_e_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q <= apc_pkg::CTRL_RST;
        end else if (clk_en && wr_en
                     && lane0_wr(paddr, apc_pkg::CTRL_ADDR)) begin
            ctrl_q <= {4'h0, pwdata[3:0]};
        end
    end

    // ************************************************************
    // bus answer
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok(paddr);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (rd_en) begin
                unique case (paddr)
                    apc_pkg::OPT_D_ADDR: prdata <= {24'h0, opt_d_q};
                    apc_pkg::OPT_E_ADDR: prdata <= {24'h0, opt_e_q};
                    apc_pkg::CTRL_ADDR:  prdata <= {24'h0, ctrl_q};
                    apc_pkg::STAT_ADDR:  prdata <= 32'(mute_q);
                    default:             prdata <= 32'h0000_0000;
                endcase
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // zero-run mute per channel
    // ************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_zm
            apc_zero_mute #(
                .RUN_LEN (RUN_LEN),
                .DW      (DW)
            ) u_zm (
                .ref_clk    (ref_clk),
                .srst       (srst),
                .clk_en     (clk_en),
                .enable     (opt_d_q[apc_pkg::ZRM_BIT]),
                .sample_vld (xover_vld[ch]),
                .sample     (xover_data[ch*DW +: DW]),
                .mute       (mute_w[ch])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mute_q <= '0;
        end else if (clk_en) begin
            mute_q <= mute_w;
        end
    end

    // ************************************************************
    // decoded controls
    // ************************************************************
    logic [1:0] osm;
    logic [1:0] ocf;
    logic       pc_allowed;
    assign osm = ctrl_q[apc_pkg::OSM_LSB +: 2];
    assign ocf = ctrl_q[apc_pkg::OCF_LSB +: 2];
    // tapered stage or binary modulation keep correction off
    assign pc_allowed = opt_e_q[apc_pkg::PCE_BIT]
                     && (osm != apc_pkg::OSM_TAPERED)
                     && (ocf != apc_pkg::OCF_BINARY);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            highpass_bypass         <= 1'b0;
            deemphasis_enable       <= 1'b0;
            eq_path_bypass          <= 1'b0;
            postscale_link          <= 1'b0;
            coefficient_link        <= 1'b0;
            compression_mode_select <= 1'b0;
            limiter_track_volume    <= 1'b0;
            sub_mix_enable          <= 1'b0;
            channel_mute            <= '0;
        end else if (clk_en) begin
            highpass_bypass   <= opt_d_q[apc_pkg::HPB_BIT];
            deemphasis_enable <= opt_d_q[apc_pkg::DEEMPHASIS_ENABLE_BIT];
            eq_path_bypass    <= opt_d_q[apc_pkg::EQBP_BIT];
            postscale_link    <= opt_d_q[apc_pkg::PSL_BIT];
            coefficient_link  <= opt_d_q[apc_pkg::CFL_BIT];
            compression_mode_select <= opt_d_q[apc_pkg::CMP_BIT];
            // thresholds follow volume only in compression mode
            limiter_track_volume <= opt_d_q[apc_pkg::CMP_BIT];
            sub_mix_enable    <= opt_d_q[apc_pkg::SMX_BIT];
            channel_mute      <= mute_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            power_corr_coef_select   <= 1'b0;
            // decoded controls start from the register reset values
            power_corr_main_active   <= apc_pkg::OPT_E_RST[apc_pkg::PCE_BIT];
            power_corr_line_active   <= 1'b0;
            shaper_order_select      <= 1'b0;
            radio_band_quiet_mode    <= 1'b0;
            modulation_rate_select   <= 1'b0;
            modulation_rate_hz       <= 20'(apc_pkg::RATE_NORM_HZ);
            distortion_coef_select   <= 1'b0;
            zero_cross_volume_enable <= apc_pkg::OPT_E_RST[apc_pkg::ZCV_BIT];
            soft_volume_enable       <= apc_pkg::OPT_E_RST[apc_pkg::SVE_BIT];
        end else if (clk_en) begin
            power_corr_coef_select <= opt_e_q[apc_pkg::PCS_BIT];
            power_corr_main_active <= pc_allowed;
            // line-out channels 3/4 unaffected in configuration 00
            power_corr_line_active <= pc_allowed
                && (ocf != apc_pkg::OCF_LINEOUT);
            shaper_order_select    <= opt_e_q[apc_pkg::SHO_BIT];
            radio_band_quiet_mode  <= opt_e_q[apc_pkg::RBQ_BIT];
            modulation_rate_select <= opt_e_q[apc_pkg::MRS_BIT];
            modulation_rate_hz <= opt_e_q[apc_pkg::MRS_BIT]
                ? 20'(apc_pkg::RATE_ODD_HZ)
                : 20'(apc_pkg::RATE_NORM_HZ);
            distortion_coef_select <= opt_e_q[apc_pkg::DCS_BIT];
            zero_cross_volume_enable <= opt_e_q[apc_pkg::ZCV_BIT];
            soft_volume_enable     <= opt_e_q[apc_pkg::SVE_BIT];
        end
    end

endmodule : apc_config_regs

`default_nettype wire

/* rtl/apc_pkg.sv */
/*
 * Constants shared by the audio processing configuration register bank:
 * register offsets, bit positions, reset values and timing counts.
 * Assumes a 32-bit APB slave with byte addresses.
 */
package apc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  OPT_D_IDX = 8'h03;
    localparam logic [7:0]  OPT_E_IDX = 8'h04;
    localparam logic [11:0] OPT_D_ADDR = 12'h00C;
    localparam logic [11:0] OPT_E_ADDR = 12'h010;
    localparam logic [11:0] CTRL_ADDR  = 12'h020;
    localparam logic [11:0] STAT_ADDR  = 12'h024;

    localparam logic [7:0] OPT_D_RST = 8'h40;
    localparam logic [7:0] OPT_E_RST = 8'hC2;
    localparam logic [7:0] CTRL_RST  = 8'h00;

    // ************************************************************
    // processing options, register at index 3
    // ************************************************************
    localparam int HPB_BIT  = 0;
    localparam int DEEMPHASIS_ENABLE_BIT = 1;
    localparam int EQBP_BIT = 2;
    localparam int PSL_BIT  = 3;
    localparam int CFL_BIT  = 4;
    localparam int CMP_BIT  = 5;
    localparam int ZRM_BIT  = 6;
    localparam int SMX_BIT  = 7;

    // ************************************************************
    // processing options, register at index 4
    // ************************************************************
    localparam int PCS_BIT  = 0;
    localparam int PCE_BIT  = 1;
    localparam int SHO_BIT  = 2;
    localparam int RBQ_BIT  = 3;
    localparam int MRS_BIT  = 4;
    localparam int DCS_BIT  = 5;
    localparam int ZCV_BIT  = 6;
    localparam int SVE_BIT  = 7;

    // control register fields (output mode, output configuration)
    localparam int OSM_LSB  = 0;
    localparam int OCF_LSB  = 2;
    localparam logic [1:0] OSM_TAPERED = 2'h1;
    localparam logic [1:0] OCF_LINEOUT = 2'h0;
    localparam logic [1:0] OCF_BINARY  = 2'h1;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int ZERO_RUN_LEN = 2048;
    localparam int RATE_NORM_HZ = 384000;
    localparam int RATE_ODD_HZ  = 341300;

endpackage : apc_pkg

/* rtl/apc_zero_mute.sv */
/*
 * Per-channel zero-run detector: counts consecutive zero samples and
 * raises a mute when the run reaches the configured length.
 * Assumes samples arrive as one-cycle strobes on ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module apc_zero_mute #(
    parameter int RUN_LEN = apc_pkg::ZERO_RUN_LEN,
    parameter int DW      = 24
) (
    input  wire logic          ref_clk,
    input  wire logic          srst,
    input  wire logic          clk_en,
    input  wire logic          enable,
    input  wire logic          sample_vld,
    input  wire logic [DW-1:0] sample,
    output logic               mute
);
    localparam int CW = $clog2(RUN_LEN + 1);
    localparam logic [CW-1:0] RUN_TOP = CW'(RUN_LEN);

    logic [CW-1:0] run_q;

    // counter saturates so a long silence keeps the channel muted
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run_q <= '0;
        end else if (clk_en && sample_vld) begin
            if (sample != '0) begin
                run_q <= '0;
            end else if (run_q != RUN_TOP) begin
                run_q <= run_q + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mute <= 1'b0;
        end else if (clk_en) begin
            mute <= enable && (run_q == RUN_TOP);
        end
    end

endmodule : apc_zero_mute

`default_nettype wire

/* verif/apc_config_regs_checker.sv */
/*
 * Assertions on the APB answer and the decoded option outputs.
 * Assumes a bind to apc_config_regs with clk_en held high.
 */
`timescale 1ns/1ns
`default_nettype none
module apc_config_regs_checker (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        highpass_bypass,
    input wire logic        deemphasis_enable,
    input wire logic        eq_path_bypass,
    input wire logic        postscale_link,
    input wire logic        coefficient_link,
    input wire logic        compression_mode_select,
    input wire logic        limiter_track_volume,
    input wire logic        sub_mix_enable,
    input wire logic        power_corr_coef_select,
    input wire logic        power_corr_main_active,
    input wire logic        power_corr_line_active,
    input wire logic        shaper_order_select,
    input wire logic        radio_band_quiet_mode,
    input wire logic        modulation_rate_select,
    input wire logic [19:0] modulation_rate_hz,
    input wire logic        distortion_coef_select,
    input wire logic        zero_cross_volume_enable,
    input wire logic        soft_volume_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [31:0] wd_q;
    wire acc = psel && penable && !pready;
    wire wr = acc && pwrite && pstrb[0];
    wire hit = paddr inside {apc_pkg::OPT_D_ADDR, apc_pkg::OPT_E_ADDR,
                             apc_pkg::CTRL_ADDR, apc_pkg::STAT_ADDR};
    // data of the last access, seen two edges later
    always_ff @(posedge ref_clk) begin
        if (acc) begin
            wd_q <= pwdata;
        end
    end
    ready_one_wait_a: assert property (acc |=> pready)
        else $error("no answer one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    d_outputs_a: assert property (
        wr && paddr == apc_pkg::OPT_D_ADDR
        |=> ##1 {sub_mix_enable, compression_mode_select, coefficient_link,
        postscale_link, eq_path_bypass, deemphasis_enable, highpass_bypass}
        == {wd_q[7], wd_q[5:0]}) else $error("options d not applied");
    e_outputs_a: assert property (
        wr && paddr == apc_pkg::OPT_E_ADDR
        |=> ##1 {soft_volume_enable, zero_cross_volume_enable,
        distortion_coef_select, modulation_rate_select, radio_band_quiet_mode,
        shaper_order_select, power_corr_coef_select}
        == {wd_q[7:2], wd_q[0]}) else $error("options e not applied");
    rate_value_a: assert property (modulation_rate_hz ==
        (modulation_rate_select ? 20'(apc_pkg::RATE_ODD_HZ)
                                : 20'(apc_pkg::RATE_NORM_HZ)))
        else $error("modulation rate mismatch");
    limiter_track_a: assert property (
        limiter_track_volume == compression_mode_select)
        else $error("limiter tracking mismatch");
    unmapped_err_a: assert property (acc && !hit
        |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    mapped_ok_a: assert property (acc && hit |=> !pslverr)
        else $error("mapped access refused");
    line_needs_main_a: assert property (
        power_corr_line_active |-> power_corr_main_active)
        else $error("line correction without main");
    cover property (wr && paddr == apc_pkg::OPT_D_ADDR);
    cover property (acc && !hit);
    cover property (power_corr_line_active);
endmodule : apc_config_regs_checker
`default_nettype wire

/* verif/apc_config_regs_tb.sv */
/*
 * Self-checking bench for the configuration register bank over APB.
 * Assumes the checker file is compiled alongside; clk_en stays high except during the frozen-mute step.
 */
`timescale 1ns/1ns
`default_nettype none
module apc_config_regs_tb;
    logic        ref_clk, srst, clk_en, psel, penable, pwrite, pready;
    logic        pslverr, er;
    logic [11:0] paddr, a;
    logic [31:0] pwdata, prdata, rd, v, o;
    logic [3:0]  pstrb, c;
    logic [2:0]  xover_vld, channel_mute;
    logic [71:0] xover_data;
    logic        highpass_bypass, deemphasis_enable, eq_path_bypass;
    logic        postscale_link, coefficient_link, compression_mode_select;
    logic        limiter_track_volume, sub_mix_enable, power_corr_coef_select;
    logic        power_corr_main_active, power_corr_line_active;
    logic        shaper_order_select, radio_band_quiet_mode;
    logic        modulation_rate_select, distortion_coef_select;
    logic        zero_cross_volume_enable, soft_volume_enable;
    logic [19:0] modulation_rate_hz;
    int          fail_count, checks, n;

    apc_config_regs #(.NCH(3), .DW(24), .RUN_LEN(8)) uut (.*);

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    // request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge ref_clk); k++; end
        while (pready !== 1'b1 && k < 20);
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k >= 20) begin fail_count++; stop_test(); end
    endtask : apb

    task automatic feed(input int cnt, input logic [23:0] s);
        repeat (cnt) begin
            @(posedge ref_clk);
            xover_vld <= 3'h7; xover_data <= {24'h000001, 24'h000001, s};
            @(posedge ref_clk);
            xover_vld <= 3'h0;
        end
    endtask : feed

    function automatic logic [1:0] pc_exp(input logic [3:0] ctl);
        logic m;
        m = ctl[1:0] != apc_pkg::OSM_TAPERED
            && ctl[3:2] != apc_pkg::OCF_BINARY;
        return {m, m && ctl[3:2] != apc_pkg::OCF_LINEOUT};
    endfunction : pc_exp

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        srst = 1'b1; clk_en = 1'b1; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hF;
        xover_vld = 3'h0; xover_data = 72'h0;
        v = $urandom(28677);
        repeat (8) @(posedge ref_clk);
        o = 32'({soft_volume_enable, zero_cross_volume_enable,
                 power_corr_main_active, power_corr_line_active});
        chk("reset hold", o, 32'hE);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        apb(0, apc_pkg::OPT_D_ADDR, 0, rd, er);
        chk("reset d", rd, 32'h40);
        apb(0, apc_pkg::OPT_E_ADDR, 0, rd, er);
        chk("reset e", rd, 32'hC2);
        o = 32'({soft_volume_enable, zero_cross_volume_enable,
                 power_corr_main_active, power_corr_line_active});
        chk("reset outs", o, 32'hE);
        chk("reset rate", modulation_rate_hz, 32'h5DC00);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            v = (i < 2) ? 32'hFF : (i < 4) ? 32'h0 : $urandom;
            a = i[0] ? apc_pkg::OPT_E_ADDR : apc_pkg::OPT_D_ADDR;
            apb(1, a, v, rd, er);
            @(posedge ref_clk);
            if (i[0]) begin
                o = 32'({soft_volume_enable, zero_cross_volume_enable,
                         distortion_coef_select, modulation_rate_select,
                         radio_band_quiet_mode, shaper_order_select,
                         power_corr_coef_select});
                chk("opt e", o, {v[7:2], v[0]});
                chk("rate", modulation_rate_hz,
                    v[4] ? 32'h53534 : 32'h5DC00);
            end else begin
                o = 32'({sub_mix_enable, compression_mode_select,
                         coefficient_link, postscale_link, eq_path_bypass,
                         deemphasis_enable, highpass_bypass});
                chk("opt d low", o[2:0], v[2:0]);
                chk("opt d hi", o[6:3], {v[7], v[5:3]});
                chk("track", limiter_track_volume, v[5]);
            end
            apb(0, a, 0, rd, er);
            chk("readback", rd, {24'h0, v[7:0]});
        end
        $display("test random options done");
        apb(1, apc_pkg::OPT_D_ADDR, 32'h5A, rd, er);
        pstrb <= 4'hE;
        apb(1, apc_pkg::OPT_D_ADDR, 32'hA5, rd, er);
        pstrb <= 4'hF;
        apb(1, 12'h014, 32'hFF, rd, er);
        chk("unmapped wr err", er, 1'b1);
        apb(0, 12'h014, 0, rd, er);
        chk("unmapped rd", {er, rd}, {1'b1, 32'h0});
        apb(0, apc_pkg::OPT_D_ADDR, 0, rd, er);
        chk("kept d", rd, 32'h5A);
        $display("test refusals done");
        apb(1, apc_pkg::OPT_E_ADDR, 32'hC2, rd, er);
        for (int j = 0; j < 16; j++) begin
            c = j[3:0];
            apb(1, apc_pkg::CTRL_ADDR, {28'h0, c}, rd, er);
            @(posedge ref_clk);
            o = 32'({power_corr_main_active, power_corr_line_active});
            chk("power corr", o, pc_exp(c));
        end
        apb(1, apc_pkg::OPT_E_ADDR, 32'hC0, rd, er);
        @(posedge ref_clk);
        chk("power corr off", power_corr_main_active, 1'b0);
        $display("test power correction done");
        apb(1, apc_pkg::OPT_D_ADDR, 32'h40, rd, er);
        feed(1, 24'h000007);
        feed(7, 24'h0);
        repeat (3) @(posedge ref_clk);
        chk("mute early", channel_mute, 3'h0);
        feed(1, 24'h0);
        n = 0;
        while (channel_mute[0] !== 1'b1 && n < 10) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 10) begin fail_count++; stop_test(); end
        chk("mute set", channel_mute, 3'h1);
        apb(0, apc_pkg::STAT_ADDR, 0, rd, er);
        chk("mute status", rd, 32'h1);
        // samples offered while frozen must not clear the mute
        clk_en <= 1'b0;
        feed(2, 24'h000005);
        clk_en <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("frozen mute", channel_mute, 3'h1);
        apb(1, apc_pkg::OPT_D_ADDR, 32'h00, rd, er);
        feed(10, 24'h0);
        chk("mute off", channel_mute, 3'h0);
        $display("test zero mute done");
        stop_test();
    end
endmodule : apc_config_regs_tb

bind apc_config_regs apc_config_regs_checker chk_i (.*);
`default_nettype wire
